// File: inc/disk_xfer_pkg.sv
// constants, types and carriers shared by the disk slave transfer port
//
// Function
// - each transfer moves 16 bits, bus a octet first, bus b octet second
// - command and response octets: bit 7 msb, numbers sent msb octet first
// - data octets carry no order meaning and are returned as written
// - commands and responses interlocked, data always streamed, never switched
// - no odd-octet mode; every transfer is a whole double octet
// - command stopped by master, no length prefix: success, partial param flagged
// - command stopped by master with length prefix: success flag set
// - response stopped by master: end transfer with success flag set
// - read or verify stopped: end at once with success, keep orientation
// - write stopped: stop requesting, pad field with fill, then success follows master status
// - stopped write with check enabled records a deliberately bad check value
// - stop during verify-then-write header gives no guaranteed verify result
// - stopped head-step transfer keeps head counter; success follows master status
// - non-buffer streaming sends one sync in per double octet at disk rate
// - sync in pulses are high for half of each period
// - write streaming starts sync in pulses n octet times before recording
// - a fifo of at least n octets absorbs round-trip delay
// - write underrun ends transfer, clears success, sets underrun status code
// - underrun with check enabled finishes the sector with a bad check value
// - parity of received octets is checked and errors reported to master
// - ending status: success bit 7, parity error bit 6, code in bits 3-0
package disk_xfer_pkg;

	// register map, byte addresses
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_LEN     = 8'h04;
	localparam logic [7:0]  ADDR_TXWORD  = 8'h08;
	localparam logic [7:0]  ADDR_RXWORD  = 8'h0c;
	localparam logic [7:0]  ADDR_STATUS  = 8'h10;

	// control field positions
	localparam int          CTRL_OP_LSB  = 0;
	localparam int          CTRL_ECC_BIT = 2;
	localparam int          CTRL_STEP_BIT = 3;
	localparam int          CTRL_PFX_BIT = 4;
	localparam int          CTRL_PW_LSB  = 8;
	localparam int          CTRL_GO_BIT  = 31;

	// ending status positions and codes
	localparam int          ST_OK_BIT    = 7;
	localparam int          ST_BPE_BIT   = 6;
	localparam logic [3:0]  ES_NONE      = 4'h0;
	localparam logic [3:0]  ES_UNDERRUN  = 4'h1;

	// reset values and the write fill pattern
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	localparam logic [15:0] LEN_RST      = 16'h0010;
	localparam logic [15:0] WORD_RST     = 16'h0000;
	localparam logic [7:0]  STATUS_RST   = 8'h00;
	localparam logic [7:0]  HEAD_RST     = 8'h00;
	localparam logic [15:0] FILL_WORD    = 16'h5a5a;

	// disk rate timing: one double octet per period
	localparam int          CLK_NS       = 10;
	localparam int          DOT_NS       = 320;
	localparam int          DOT_CYC      = DOT_NS / CLK_NS;
	localparam logic [4:0]  DOT_LAST     = 5'(DOT_CYC - 1);
	localparam logic [4:0]  HALF_CYC     = 5'(DOT_CYC / 2);

	// prefetch buffer
	localparam int          FIFO_AW      = 3;
	localparam int          FIFO_WORDS   = 1 << FIFO_AW;
	localparam int          PREFETCH_OCTETS = 8;
	localparam logic [2:0]  PREFETCH_DOTS = 3'(PREFETCH_OCTETS / 2);

	typedef enum logic [1:0] {
		OP_CMD,
		OP_RSP,
		OP_READ,
		OP_WRITE
	} op_e;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CMD_WAIT,
		ST_CMD_ACK,
		ST_RSP_WAIT,
		ST_RSP_REQ,
		ST_RSP_REL,
		ST_STREAM
	} state_e;

	typedef struct packed {
		logic [7:0] a;
		logic       a_par;
		logic [7:0] b;
		logic       b_par;
		logic       sync_out;
		logic       stop;
	} link_in_s;

	typedef struct packed {
		logic [7:0] a;
		logic       a_par;
		logic [7:0] b;
		logic       b_par;
		logic       oe_n;
		logic       sync_in;
	} link_out_s;

	localparam link_out_s LINK_RST = '{oe_n: 1'b1, default: '0};

endpackage : disk_xfer_pkg

// File: design/fifo_mem.sv
// word storage for the streaming prefetch buffer
module fifo_mem
	import disk_xfer_pkg::*;
(
	input  wire logic               hclk,
	input  wire logic               we,
	input  wire logic [FIFO_AW-1:0] waddr,
	input  wire logic [15:0]        wdata,
	input  wire logic [FIFO_AW-1:0] raddr,
	output logic      [15:0]        rdata
);

	logic [15:0] mem_q [FIFO_WORDS];

	always_ff @(posedge hclk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
		rdata <= mem_q[raddr];
	end

endmodule : fifo_mem

// File: design/disk_xfer_port.sv
// disk slave transfer port: register slave, interlocked and streaming engine
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
module disk_xfer_port
	import disk_xfer_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	input  wire link_in_s    link_i,
	output link_out_s        link_o,
	input  wire logic        media_bit_i,
	output logic             media_bit_o,
	output logic             write_gate_o,
	output logic             bad_check_o
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	link_in_s               lk1_q, lk2_q;
	logic                   med1_q, med2_q, so_prev_q, stop_prev_q;
	logic                   so_rise, stop_rise, pe_now;

	logic [31:0]            ctrl_q, ctrl_d;
	logic [15:0]            len_q, len_d, txw_q, txw_d;
	logic [31:0]            hrdata_q, hrdata_d;
	logic                   wp_q, wp_d, hready_q, hresp_q;
	logic [7:0]             widx_q, widx_d;
	logic                   go, tx_set, rx_clr, busy;

	state_e                 st_q, st_d;
	op_e                    op_q, op_d;
	logic [15:0]            words_q, words_d, pulses_q, pulses_d;
	logic [4:0]             dot_q, dot_d;
	logic [2:0]             dots_q, dots_d;
	logic                   media_on_q, media_on_d, stopping_q, stopping_d;
	logic                   term_q, term_d, under_q, under_d;
	logic                   load_q, load_d, fill_q, fill_d;
	logic [15:0]            shift_q, shift_d, rx_sh_q, rx_sh_d;
	logic [3:0]             ppos_q, ppos_d, pw;
	logic                   inval_q, inval_d, bpe_q, bpe_d, mok_q, mok_d;
	logic [7:0]             status_q, status_d, head_q, head_d;
	logic [15:0]            rx_word_q, rx_word_d;
	logic                   rx_full_q, rx_full_d, tx_full_q, tx_full_d;
	link_out_s              link_q, link_d;
	logic                   media_q, media_d, gate_q, gate_d, bad_q, bad_d;
	logic [FIFO_AW:0]       wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d, fcnt;
	logic                   fifo_we, fin, fin_ok;
	logic [3:0]             fin_es;
	logic [15:0]            fifo_rdata;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; only the second stage feeds logic

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lk1_q       <= '0;
			lk2_q       <= '0;
			med1_q      <= 1'b0;
			med2_q      <= 1'b0;
			so_prev_q   <= 1'b0;
			stop_prev_q <= 1'b0;
		end else begin
			lk1_q       <= link_i;
			lk2_q       <= lk1_q;
			med1_q      <= media_bit_i;
			med2_q      <= med1_q;
			so_prev_q   <= lk2_q.sync_out;
			stop_prev_q <= lk2_q.stop;
		end
	end

	assign so_rise   = lk2_q.sync_out & ~so_prev_q;
	assign stop_rise = lk2_q.stop & ~stop_prev_q;
	// odd parity per octet
	assign pe_now    = ~(^{lk2_q.a, lk2_q.a_par}) | ~(^{lk2_q.b, lk2_q.b_par});
	assign busy      = (st_q != ST_IDLE);
	assign fcnt      = wr_ptr_q - rd_ptr_q;
	assign pw        = (ctrl_q[CTRL_PW_LSB +: 4] == 4'h0) ? 4'h1
	                   : ctrl_q[CTRL_PW_LSB +: 4];

	////////////////////////////////////////////////////////////////////////
	// register slave: zero wait states, read data prepared in address phase

	always_comb begin
		ctrl_d   = ctrl_q;
		len_d    = len_q;
		txw_d    = txw_q;
		hrdata_d = hrdata_q;
		wp_d     = 1'b0;
		widx_d   = widx_q;
		go       = 1'b0;
		tx_set   = 1'b0;
		rx_clr   = 1'b0;
		if (wp_q) begin
			case (widx_q)
				ADDR_CTRL: begin
					ctrl_d = hwdata;
					ctrl_d[CTRL_GO_BIT] = 1'b0;
					go = hwdata[CTRL_GO_BIT];
				end
				ADDR_LEN: len_d = hwdata[15:0];
				ADDR_TXWORD: begin
					txw_d  = hwdata[15:0];
					tx_set = 1'b1;
				end
				default: ;
			endcase
		end
		if (hsel && htrans[1] && hready) begin
			if (hwrite) begin
				wp_d   = (haddr[31:8] == 24'h0);
				widx_d = haddr[7:0];
			end else if (haddr[31:8] != 24'h0) begin
				hrdata_d = '0;
			end else begin
				case (haddr[7:0])
					ADDR_CTRL:   hrdata_d = ctrl_q;
					ADDR_LEN:    hrdata_d = {16'h0, len_q};
					ADDR_TXWORD: hrdata_d = {16'h0, txw_q};
					ADDR_RXWORD: begin
						hrdata_d = {16'h0, rx_word_q};
						rx_clr   = 1'b1;
					end
					ADDR_STATUS: hrdata_d = {8'h00, head_q, 4'h0, rx_full_q,
					                         tx_full_q, inval_q, busy, status_q};
					default:     hrdata_d = '0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q   <= CTRL_RST;
			len_q    <= LEN_RST;
			txw_q    <= WORD_RST;
			hrdata_q <= '0;
			wp_q     <= 1'b0;
			widx_q   <= '0;
			hready_q <= 1'b1;
			hresp_q  <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			len_q    <= len_d;
			txw_q    <= txw_d;
			hrdata_q <= hrdata_d;
			wp_q     <= wp_d;
			widx_q   <= widx_d;
			hready_q <= 1'b1;
			hresp_q  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transfer engine

	always_comb begin
		st_d       = st_q;
		op_d       = op_q;
		words_d    = words_q;
		pulses_d   = pulses_q;
		dot_d      = dot_q;
		dots_d     = dots_q;
		media_on_d = media_on_q;
		stopping_d = stopping_q;
		term_d     = term_q;
		under_d    = under_q;
		load_d     = 1'b0;
		fill_d     = 1'b0;
		shift_d    = shift_q;
		rx_sh_d    = rx_sh_q;
		ppos_d     = ppos_q;
		inval_d    = inval_q;
		bpe_d      = bpe_q;
		mok_d      = mok_q;
		status_d   = status_q;
		head_d     = head_q;
		rx_word_d  = rx_word_q;
		rx_full_d  = rx_full_q;
		tx_full_d  = tx_full_q;
		link_d     = link_q;
		media_d    = media_q;
		gate_d     = gate_q;
		bad_d      = 1'b0;
		wr_ptr_d   = wr_ptr_q;
		rd_ptr_d   = rd_ptr_q;
		fifo_we    = 1'b0;
		fin        = 1'b0;
		fin_ok     = 1'b1;
		fin_es     = ES_NONE;
		if (rx_clr) begin
			rx_full_d = 1'b0;
		end
		case (st_q)
			ST_IDLE: begin
				if (go) begin
					// mode follows the operation and cannot be chosen
					op_d       = op_e'(ctrl_d[CTRL_OP_LSB +: 2]);
					words_d    = len_q;
					pulses_d   = len_q;
					dot_d      = '0;
					dots_d     = '0;
					media_on_d = 1'b0;
					stopping_d = 1'b0;
					term_d     = 1'b0;
					under_d    = 1'b0;
					ppos_d     = '0;
					inval_d    = 1'b0;
					bpe_d      = 1'b0;
					mok_d      = 1'b1;
					wr_ptr_d   = '0;
					rd_ptr_d   = '0;
					link_d.oe_n = (op_d != OP_READ);
					case (op_d)
						OP_CMD:  st_d = ST_CMD_WAIT;
						OP_RSP:  st_d = ST_RSP_WAIT;
						default: st_d = ST_STREAM;
					endcase
					if (len_q == 16'h0) begin
						fin = 1'b1;
					end
				end
			end
			ST_CMD_WAIT, ST_CMD_ACK: begin
				if (stop_rise) begin
					fin = 1'b1;
					// a command without a length prefix flags a partly received parameter
					inval_d = !ctrl_q[CTRL_PFX_BIT] && (ppos_q != 4'h0);
				end else if (st_q == ST_CMD_WAIT && lk2_q.sync_out) begin
					// bus a octet is the earlier, high octet of the word
					rx_word_d = {lk2_q.a, lk2_q.b};
					rx_full_d = 1'b1;
					bpe_d     = bpe_q | pe_now;
					ppos_d    = (ppos_q + 4'h1 >= pw) ? 4'h0 : ppos_q + 4'h1;
					link_d.sync_in = 1'b1;
					st_d      = ST_CMD_ACK;
				end else if (st_q == ST_CMD_ACK && !lk2_q.sync_out) begin
					link_d.sync_in = 1'b0;
					words_d   = words_q - 16'h1;
					st_d      = ST_CMD_WAIT;
					fin       = (words_q == 16'h1);
				end
			end
			ST_RSP_WAIT, ST_RSP_REQ, ST_RSP_REL: begin
				if (stop_rise) begin
					fin = 1'b1;
				end else if (st_q == ST_RSP_WAIT && tx_full_q) begin
					link_d.a     = txw_q[15:8];
					link_d.b     = txw_q[7:0];
					link_d.a_par = ~^txw_q[15:8];
					link_d.b_par = ~^txw_q[7:0];
					link_d.oe_n  = 1'b0;
					link_d.sync_in = 1'b1;
					tx_full_d    = 1'b0;
					st_d         = ST_RSP_REQ;
				end else if (st_q == ST_RSP_REQ && lk2_q.sync_out) begin
					link_d.sync_in = 1'b0;
					st_d         = ST_RSP_REL;
				end else if (st_q == ST_RSP_REL && !lk2_q.sync_out) begin
					words_d      = words_q - 16'h1;
					st_d         = ST_RSP_WAIT;
					fin          = (words_q == 16'h1);
				end
			end
			ST_STREAM: begin
				dot_d = (dot_q == DOT_LAST) ? 5'h0 : dot_q + 5'h1;
				if (dot_q == HALF_CYC) begin
					link_d.sync_in = 1'b0;
				end
				if (op_q == OP_WRITE) begin
					if (stop_rise && !stopping_q) begin
						term_d     = 1'b1;
						stopping_d = 1'b1;
						// a pulse already under way keeps its full width
						mok_d      = lk2_q.a[7];
					end
					if (so_rise && !stopping_q && !fcnt[FIFO_AW]) begin
						fifo_we  = 1'b1;
						wr_ptr_d = wr_ptr_q + 1'b1;
						bpe_d    = bpe_q | pe_now;
					end
					if (dot_q == 5'h0) begin
						// pulses run free of sync out, paced by the disk
						if (pulses_q != 16'h0 && !stopping_d) begin
							link_d.sync_in = 1'b1;
							pulses_d = pulses_q - 16'h1;
						end
						// recording waits n octet times after the first pulse
						if (media_on_q || dots_q == PREFETCH_DOTS) begin
							media_on_d = 1'b1;
							gate_d     = 1'b1;
							if (words_q == 16'h0) begin
								fin    = 1'b1;
								fin_ok = !under_q && (!term_q || mok_q);
								fin_es = under_q ? ES_UNDERRUN : ES_NONE;
							end else begin
								words_d = words_q - 16'h1;
								load_d  = 1'b1;
								if (stopping_d) begin
									fill_d = 1'b1;
								end else if (fcnt == '0) begin
									if (ctrl_q[CTRL_ECC_BIT]) begin
										under_d    = 1'b1;
										stopping_d = 1'b1;
										fill_d     = 1'b1;
										link_d.sync_in = 1'b0;
									end else begin
										fin    = 1'b1;
										fin_ok = 1'b0;
										fin_es = ES_UNDERRUN;
									end
								end else begin
									rd_ptr_d = rd_ptr_q + 1'b1;
								end
							end
						end else begin
							dots_d = dots_q + 3'h1;
						end
					end
					// bus a bit 7 leaves first, two clocks per bit
					if (load_q) begin
						shift_d = fill_q ? FILL_WORD : fifo_rdata;
					end else if (dot_q[0]) begin
						shift_d = {shift_q[14:0], 1'b0};
					end
					media_d = shift_d[15];
				end else begin
					// read and verify: media state is left as it was
					if (stop_rise) begin
						fin    = 1'b1;
						fin_ok = !ctrl_q[CTRL_STEP_BIT] || lk2_q.a[7];
						term_d = 1'b1;
					end else begin
						if (dot_q[0]) begin
							rx_sh_d = {rx_sh_q[14:0], med2_q};
						end
						if (dot_q == 5'h0) begin
							if (dots_q == 3'h0) begin
								dots_d = 3'h1;
							end else if (words_q == 16'h0) begin
								fin = 1'b1;
							end else begin
								link_d.a     = rx_sh_q[15:8];
								link_d.b     = rx_sh_q[7:0];
								link_d.a_par = ~^rx_sh_q[15:8];
								link_d.b_par = ~^rx_sh_q[7:0];
								link_d.sync_in = 1'b1;
								words_d      = words_q - 16'h1;
							end
						end
					end
				end
			end
			default: st_d = ST_IDLE;
		endcase
		if (fin) begin
			st_d           = ST_IDLE;
			status_d       = {fin_ok, bpe_d, 2'b00, fin_es};
			link_d.sync_in = 1'b0;
			link_d.oe_n    = 1'b1;
			gate_d         = 1'b0;
			media_d        = 1'b0;
			// with check enabled, a stopped or starved write leaves a check value that fails
			bad_d = ctrl_q[CTRL_ECC_BIT] && (op_q == OP_WRITE) &&
			        (term_d || under_d);
			// verify-then-write stopped in the header: verify result unspecified
			if (ctrl_q[CTRL_STEP_BIT] && op_q[1] && !term_d && !under_d) begin
				head_d = head_q + 8'h1;
			end
		end
		if (tx_set) begin
			tx_full_d = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q       <= ST_IDLE;
			op_q       <= OP_CMD;
			words_q    <= '0;
			pulses_q   <= '0;
			dot_q      <= '0;
			dots_q     <= '0;
			media_on_q <= 1'b0;
			stopping_q <= 1'b0;
			term_q     <= 1'b0;
			under_q    <= 1'b0;
			load_q     <= 1'b0;
			fill_q     <= 1'b0;
			shift_q    <= WORD_RST;
			rx_sh_q    <= WORD_RST;
			ppos_q     <= '0;
			inval_q    <= 1'b0;
			bpe_q      <= 1'b0;
			mok_q      <= 1'b1;
			status_q   <= STATUS_RST;
			head_q     <= HEAD_RST;
			rx_word_q  <= WORD_RST;
			rx_full_q  <= 1'b0;
			tx_full_q  <= 1'b0;
			link_q     <= LINK_RST;
			media_q    <= 1'b0;
			gate_q     <= 1'b0;
			bad_q      <= 1'b0;
			wr_ptr_q   <= '0;
			rd_ptr_q   <= '0;
		end else begin
			st_q       <= st_d;
			op_q       <= op_d;
			words_q    <= words_d;
			pulses_q   <= pulses_d;
			dot_q      <= dot_d;
			dots_q     <= dots_d;
			media_on_q <= media_on_d;
			stopping_q <= stopping_d;
			term_q     <= term_d;
			under_q    <= under_d;
			load_q     <= load_d;
			fill_q     <= fill_d;
			shift_q    <= shift_d;
			rx_sh_q    <= rx_sh_d;
			ppos_q     <= ppos_d;
			inval_q    <= inval_d;
			bpe_q      <= bpe_d;
			mok_q      <= mok_d;
			status_q   <= status_d;
			head_q     <= head_d;
			rx_word_q  <= rx_word_d;
			rx_full_q  <= rx_full_d;
			tx_full_q  <= tx_full_d;
			link_q     <= link_d;
			media_q    <= media_d;
			gate_q     <= gate_d;
			bad_q      <= bad_d;
			wr_ptr_q   <= wr_ptr_d;
			rd_ptr_q   <= rd_ptr_d;
		end
	end

	// prefetch buffer of n octets or more
	fifo_mem u_fifo_mem (
		.hclk  (hclk),
		.we    (fifo_we),
		.waddr (wr_ptr_q[FIFO_AW-1:0]),
		.wdata ({lk2_q.a, lk2_q.b}),
		.raddr (rd_ptr_q[FIFO_AW-1:0]),
		.rdata (fifo_rdata)
	);

	assign hreadyout    = hready_q;
	assign hrdata       = hrdata_q;
	assign hresp        = hresp_q;
	assign link_o       = link_q;
	assign media_bit_o  = media_q;
	assign write_gate_o = gate_q;
	assign bad_check_o  = bad_q;

	////////////////////////////////////////////////////////////////////////
	// assertions

	property p_sync_half;
		@(posedge hclk) disable iff (!hresetn || st_q != ST_STREAM)
		($rose(link_q.sync_in) && st_q == ST_STREAM && !stop_rise)
		|-> ##15 link_q.sync_in ##1 !link_q.sync_in;
	endproperty
	a_sync_half: assert property (p_sync_half)
		else $error("sync in not high for half a period");

	property p_no_pulse_stopping;
		@(posedge hclk) disable iff (!hresetn)
		stopping_q |-> !$rose(link_q.sync_in);
	endproperty
	a_no_pulse_stopping: assert property (p_no_pulse_stopping)
		else $error("sync in pulsed after write was stopped");

	property p_underrun_code;
		@(posedge hclk) disable iff (!hresetn)
		$fell(busy) |-> ((status_q[3:0] == ES_UNDERRUN) == !status_q[ST_OK_BIT]);
	endproperty
	a_underrun_code: assert property (p_underrun_code)
		else $error("success flag and underrun code disagree");

	property p_head_hold;
		@(posedge hclk) disable iff (!hresetn)
		(term_q && busy) |=> $stable(head_q);
	endproperty
	a_head_hold: assert property (p_head_hold)
		else $error("head counter moved after master stop");

	property p_parity_flag;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == ST_CMD_WAIT && lk2_q.sync_out && !stop_rise && pe_now)
		|=> bpe_q;
	endproperty
	a_parity_flag: assert property (p_parity_flag)
		else $error("parity error not recorded");

	property p_prefetch_fits;
		@(posedge hclk) disable iff (!hresetn)
		PREFETCH_OCTETS <= 2 * FIFO_WORDS;
	endproperty
	a_prefetch_fits: assert property (p_prefetch_fits)
		else $error("prefetch depth exceeds fifo size");

	property p_ctl_stop_ok;
		@(posedge hclk) disable iff (!hresetn)
		(stop_rise && st_q inside {ST_CMD_WAIT, ST_CMD_ACK, ST_RSP_WAIT,
		 ST_RSP_REQ, ST_RSP_REL}) |=> !busy && status_q[ST_OK_BIT];
	endproperty
	a_ctl_stop_ok: assert property (p_ctl_stop_ok)
		else $error("stopped control transfer did not end with success");

	property p_read_stop;
		@(posedge hclk) disable iff (!hresetn)
		(stop_rise && st_q == ST_STREAM && op_q != OP_WRITE &&
		 !ctrl_q[CTRL_STEP_BIT]) |=> st_q == ST_IDLE && status_q[ST_OK_BIT]
		 && link_q.oe_n;
	endproperty
	a_read_stop: assert property (p_read_stop)
		else $error("read not ended at once on master stop");

	property p_fill_load;
		@(posedge hclk) disable iff (!hresetn)
		(load_q && fill_q) |=> shift_q == FILL_WORD ##2 media_q == FILL_WORD[14];
	endproperty
	a_fill_load: assert property (p_fill_load)
		else $error("fill pattern not recorded");

endmodule : disk_xfer_port

// File: test/link_master.sv
// far-side controller model driving the disk port link
module link_master
	import disk_xfer_pkg::*;
(
	input  wire logic        lclk,
	input  wire logic [1:0]  mode,
	input  wire logic        stop,
	input  wire logic        perr,
	input  wire logic [15:0] base,
	input  wire link_out_s   link_o,
	output link_in_s         link_i,
	output logic [7:0]       cnt
);
	timeunit 1ns / 1ps;
	logic        so_q, so_d;
	logic [15:0] w;
	logic [7:0]  a;
	// out of a frame the lines show the inverse, so nothing stale can match
	assign w = mode != 2'h0 ? base + 16'(cnt) : ~(base + 16'(cnt));
	assign a = stop ? 8'h80 : w[15:8];
	assign link_i = '{a: a, a_par: ~^a ^ perr, b: w[7:0], b_par: ~^w[7:0],
		sync_out: so_q, stop: stop};
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		case (mode)
			2'h1: so_d = !link_o.sync_in && (so_q || !stop);
			2'h2: so_d = link_o.sync_in && !stop;
			default: so_d = 1'b0; // stalled master, forces underrun
		endcase
	end
	always_ff @(posedge lclk) begin
		so_q <= so_d;
		cnt  <= mode == 2'h0 ? 8'h0 : cnt + 8'(so_q && !so_d);
	end
endmodule : link_master

// File: test/tb_disk_xfer_port.sv
// self-checking bench for the disk slave transfer port
module tb_disk_xfer_port
	import disk_xfer_pkg::*;
;
	timeunit 1ns / 1ps;
	logic        hclk = 1'b0, lclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
	logic        hwrite = 1'b0, stop = 1'b0, perr = 1'b0;
	logic        hreadyout, bad_check;
	logic [1:0]  htrans = 2'h0, mode = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [7:0]  cnt, b0, bad = 8'h0, hi = 8'h0, hlen = 8'h0;
	link_in_s    li;
	link_out_s   lo;
	logic        media, gate;
	logic [15:0] gt = 16'h0, mw = 16'h0;
	int          failures = 0, comparisons = 0, ticks = 0, j;
	always #5 hclk = ~hclk;
	initial #3 forever #40 lclk = ~lclk;
	always @(posedge hclk) begin
		bad <= bad + 8'(bad_check);
		hi  <= lo.sync_in ? hi + 8'h1 : 8'h0;
		if (!lo.sync_in && hi != 8'h0) hlen <= hi;
		gt  <= gate ? gt + 16'h1 : 16'h0;
		if (gate && gt < 16'h20 && gt[0]) mw <= {mw[14:0], media};
	end
	////////////////////////////////////////////////////////////////////////
	disk_xfer_port uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
		.hresp(), .link_i(li), .link_o(lo), .media_bit_i(1'b0),
		.media_bit_o(media), .write_gate_o(gate), .bad_check_o(bad_check));
	link_master far (.lclk, .mode, .stop, .perr, .base(16'hc3a5),
		.link_o(lo), .link_i(li), .cnt);
	task automatic end_of_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	task automatic step();
		@(posedge hclk);
		ticks++;
		if (ticks > 60000) begin
			failures++;
			$display("[FAIL] run expected end seen hang");
			end_of_test();
		end
	endtask : step
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		do step(); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do step(); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic idle();
		do ahb(1'b0, ADDR_STATUS, 32'h0); while (rd[8] !== 1'b0);
	endtask : idle
	task automatic go(logic [31:0] c, logic [15:0] n);
		ahb(1'b1, ADDR_LEN, {16'h0, n});
		ahb(1'b1, ADDR_CTRL, c | 32'h8000_0000);
	endtask : go
	task automatic wc(logic [7:0] n);
		while (cnt < n) step();
	endtask : wc
	task automatic pause();
		mode <= 2'h0;
		stop <= 1'b0;
		perr <= 1'b0;
		repeat (24) step();
	endtask : pause
	initial begin
		repeat (4) step();
		hresetn <= 1'b1;
		ahb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl", CTRL_RST, rd);
		ahb(1'b0, ADDR_LEN, 32'h0);
		chk("len", 32'(LEN_RST), rd);
		ahb(1'b0, 8'h40, 32'h0);
		chk("hole", 32'h0, rd);
		$display("regs done");
		mode <= 2'h1;
		go(32'(OP_CMD), 16'h3);
		idle();
		chk("cmd st", 32'h80, 32'(rd[7:0]));
		ahb(1'b0, ADDR_RXWORD, 32'h0);
		chk("cmd word", 32'hc3a7, 32'(rd[15:0]));
		pause();
		mode <= 2'h1;
		perr <= 1'b1;
		go(32'(OP_CMD), 16'h1);
		idle();
		chk("parity", 32'h1, 32'(rd[6]));
		pause();
		for (j = 0; j < 2; j++) begin
			mode <= 2'h1;
			go(32'h200 | 32'(j << 4), 16'h4);
			wc(8'h3);
			stop <= 1'b1;
			idle();
			chk("cmd stop", 32'h1, 32'(rd[7]));
			chk("partial", 32'(1 - j), 32'(rd[9]));
			pause();
		end
		$display("cmd done");
		mode <= 2'h2;
		go(32'(OP_RSP), 16'h1);
		ahb(1'b1, ADDR_TXWORD, 32'h1234);
		while (lo.sync_in !== 1'b1) step();
		chk("rsp word", 32'h1234, 32'({lo.oe_n, lo.a, lo.b}));
		idle();
		chk("rsp st", 32'h80, 32'(rd[7:0]));
		go(32'(OP_RSP), 16'h2);
		stop <= 1'b1;
		idle();
		chk("rsp stop", 32'h80, 32'(rd[7:0]));
		pause();
		$display("rsp done");
		for (j = 0; j < 2; j++) begin
			mode <= 2'h3;
			b0 = bad;
			go(32'(OP_WRITE) | 32'(j << 2), 16'h4);
			idle();
			chk("underrun", 32'(ES_UNDERRUN), 32'(rd[7:0]));
			pause();
			chk("bad check", 32'(j), 32'(bad - b0));
		end
		mode <= 2'h2;
		b0 = bad;
		go(32'(OP_WRITE) | 32'hc, 16'h10);
		wc(8'h6);
		stop <= 1'b1;
		idle();
		chk("wr stop", 32'h1, 32'(rd[7]));
		chk("head", 32'(HEAD_RST), 32'(rd[23:16]));
		chk("media word", 32'hc3a5, 32'(mw));
		chk("sync hi", 32'(HALF_CYC), 32'(hlen));
		pause();
		chk("bad check", 32'h1, 32'(bad - b0));
		mode <= 2'h2;
		go(32'(OP_READ), 16'h10);
		wc(8'h2);
		stop <= 1'b1;
		idle();
		chk("rd stop", 32'h80, 32'(rd[7:0]));
		pause();
		$display("stream done");
		end_of_test();
	end
endmodule : tb_disk_xfer_port
